// ===== include/gdio_pkg.sv
`default_nettype none
package gdio_pkg;
    // ****************************************
    // Register map, word index on the 3-bit address
    // ****************************************
    localparam int GDIO_ADDR_W = 3;
    localparam int GDIO_DATA_W = 8;
    localparam logic [2:0] GDIO_ADDR_PIN = 3'h0;
    localparam logic [2:0] GDIO_ADDR_DIR = 3'h1;
    localparam logic [2:0] GDIO_ADDR_DATA = 3'h2;
    localparam logic [2:0] GDIO_ADDR_CTRL = 3'h3;
    localparam logic [2:0] GDIO_ADDR_DIR_SET = 3'h4;
    localparam logic [2:0] GDIO_ADDR_DIR_CLR = 3'h5;
    localparam logic [2:0] GDIO_ADDR_DATA_SET = 3'h6;
    localparam logic [2:0] GDIO_ADDR_DATA_CLR = 3'h7;

    // ****************************************
    // Control register layout and reset values
    // ****************************************
    localparam int GDIO_CTRL_PUD_BIT = 4;
    localparam logic [7:0] GDIO_CTRL_WMASK = 8'h1F;
    localparam logic [7:0] GDIO_CTRL_RESET = 8'h00;
    localparam logic [7:0] GDIO_PORT_RESET = 8'h00;

    // ****************************************
    // Synchroniser timing: pin change to readable bit
    // ****************************************
    localparam int GDIO_SW_READBACK_CYCLES = 1;

    // ****************************************
    // Bit update used by the set and clear windows
    // ****************************************
    function automatic logic [7:0] gdio_mask_update(input logic [7:0] old_val,
                                                   input logic [7:0] mask,
                                                   input logic set_not_clr);
        gdio_mask_update = set_not_clr ? (old_val | mask) : (old_val & ~mask);
    endfunction
endpackage
`default_nettype wire

// ===== hw/gdio_pin_sync.sv
`default_nettype none
module gdio_pin_sync
    import gdio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_pin_in,
    output logic [WIDTH-1:0] o_pin_sync
);
    // ****************************************
    // Half-cycle capture stage, stands in for the latch open while clock is high
    // ****************************************
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = i_srst ? '0 : i_pin_in;
        sync_d = i_srst ? '0 : meta_q;
    end

    // Falling-edge capture gives the half to one and a half cycle delay
    always_ff @(negedge i_core_clk) begin
        meta_q <= meta_d;
    end

    // Only the second stage looks at the first
    always_ff @(posedge i_core_clk) begin
        sync_q <= sync_d;
    end

    assign o_pin_sync = sync_q;
endmodule
`default_nettype wire

// ===== hw/gdio_pin_drive.sv
`default_nettype none
module gdio_pin_drive
    import gdio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_dir,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_pud,
    input wire logic [WIDTH-1:0] i_alt_sel,
    input wire logic [WIDTH-1:0] i_alt_oe,
    input wire logic [WIDTH-1:0] i_alt_out,
    output logic [WIDTH-1:0] o_pin_out,
    output logic [WIDTH-1:0] o_pin_oe,
    output logic [WIDTH-1:0] o_pin_pullup
);
    // ****************************************
    // Per-pin drive, pull-up and override mux
    // ****************************************
    logic [WIDTH-1:0] gp_oe;
    logic [WIDTH-1:0] gp_pullup;

    always_comb begin
        gp_oe = i_dir;
        gp_pullup = ~i_dir & i_data & {WIDTH{~i_pud}};
        // Override is per pin, so unselected pins keep plain behaviour
        o_pin_oe = ((i_alt_sel & i_alt_oe) | (~i_alt_sel & gp_oe)) & {WIDTH{~i_srst}};
        o_pin_out = ((i_alt_sel & i_alt_out) | (~i_alt_sel & i_data)) & o_pin_oe;
        // Reset gating is combinational so pins float even with the clock stopped
        o_pin_pullup = ~i_alt_sel & gp_pullup & {WIDTH{~i_srst}};
    end
endmodule
`default_nettype wire

// ===== hw/gdio_port.sv
`default_nettype none
// Behaviour
// - Direction one means output, zero input
// - Input pin with data one gets pull-up
// - Pull-up off on data zero or output
// - Pull-up only for dir 0, data 1, no disable
// - Global disable kills all pull-ups; here the bit clears only this port's pull-ups
// - Reset tri-states pins without a clock
// - Output pin drives its data bit
// - Writing one to input reg toggles data
// - Data, direction and input registers per port
// - Single-bit set and clear of direction, data
// - Overridden pins leave others as plain I/O
// - Control resets zero, bits 7 to 5 zero
// - Pin seen after half to 1.5 cycles
// - Software-driven level readable one cycle later
// - Pin readable whatever the direction
module gdio_port
    import gdio_pkg::*;
#(
    parameter int PINS = 8
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic [GDIO_ADDR_W-1:0] i_addr,
    input wire logic [GDIO_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [GDIO_DATA_W-1:0] o_rdata,
    input wire logic [PINS-1:0] i_pin_in,
    output logic [PINS-1:0] o_pin_out,
    output logic [PINS-1:0] o_pin_oe,
    output logic [PINS-1:0] o_pin_pullup,
    input wire logic [PINS-1:0] i_alt_sel,
    input wire logic [PINS-1:0] i_alt_oe,
    input wire logic [PINS-1:0] i_alt_out,
    output logic o_global_pullup_disable
);
    // ****************************************
    // Register state
    // ****************************************
    logic [PINS-1:0] dir_q;
    logic [PINS-1:0] dir_d;
    logic [PINS-1:0] data_q;
    logic [PINS-1:0] data_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [GDIO_DATA_W-1:0] rdata_q;
    logic [GDIO_DATA_W-1:0] rdata_d;
    logic [PINS-1:0] pin_in_sync;
    logic [PINS-1:0] wmask;
    logic global_pullup_disable;

    assign wmask = i_wdata[PINS-1:0];
    assign global_pullup_disable = ctrl_q[GDIO_CTRL_PUD_BIT];

    // ****************************************
    // Next-state for the port registers
    // ****************************************
    always_comb begin
        dir_d = dir_q;
        data_d = data_q;
        ctrl_d = ctrl_q;
        if (i_wr) begin
            case (i_addr)
                GDIO_ADDR_PIN: begin
                    data_d = data_q ^ wmask;
                end
                GDIO_ADDR_DIR: begin
                    dir_d = wmask;
                end
                GDIO_ADDR_DATA: begin
                    data_d = wmask;
                end
                GDIO_ADDR_CTRL: begin
                    ctrl_d = i_wdata & GDIO_CTRL_WMASK;
                end
                GDIO_ADDR_DIR_SET: begin
                    dir_d = gdio_mask_update(dir_q, wmask, 1'b1);
                end
                GDIO_ADDR_DIR_CLR: begin
                    dir_d = gdio_mask_update(dir_q, wmask, 1'b0);
                end
                GDIO_ADDR_DATA_SET: begin
                    data_d = gdio_mask_update(data_q, wmask, 1'b1);
                end
                GDIO_ADDR_DATA_CLR: begin
                    data_d = gdio_mask_update(data_q, wmask, 1'b0);
                end
                default: begin
                    dir_d = dir_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            dir_q <= GDIO_PORT_RESET[PINS-1:0];
            data_q <= GDIO_PORT_RESET[PINS-1:0];
            ctrl_q <= GDIO_CTRL_RESET;
        end else begin
            dir_q <= dir_d;
            data_q <= data_d;
            ctrl_q <= ctrl_d;
        end
    end

    // ****************************************
    // Read path, data valid only in the cycle after the strobe
    // ****************************************
    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            case (i_addr)
                GDIO_ADDR_PIN: begin
                    rdata_d[PINS-1:0] = pin_in_sync;
                end
                GDIO_ADDR_DIR: begin
                    rdata_d[PINS-1:0] = dir_q;
                end
                GDIO_ADDR_DATA: begin
                    rdata_d[PINS-1:0] = data_q;
                end
                GDIO_ADDR_CTRL: begin
                    rdata_d = ctrl_q & GDIO_CTRL_WMASK;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    // Copy of the control bit for the top level; no port takes it in, so it disables only this port's pull-ups
    assign o_global_pullup_disable = global_pullup_disable;

    // ****************************************
    // Pin side
    // ****************************************
    // The driven level loops back through the pad, so readback lands one cycle on
    gdio_pin_sync #(.WIDTH(PINS)) u_sync (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_pin_in(i_pin_in),
        .o_pin_sync(pin_in_sync)
    );

    gdio_pin_drive #(.WIDTH(PINS)) u_drive (
        .i_srst(i_srst),
        .i_dir(dir_q),
        .i_data(data_q),
        .i_pud(global_pullup_disable),
        .i_alt_sel(i_alt_sel),
        .i_alt_oe(i_alt_oe),
        .i_alt_out(i_alt_out),
        .o_pin_out(o_pin_out),
        .o_pin_oe(o_pin_oe),
        .o_pin_pullup(o_pin_pullup)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    property p_dir_oe;
        (i_alt_sel == '0) |-> (o_pin_oe == dir_q);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("oe does not follow direction");

    property p_pullup;
        (i_alt_sel == '0) |-> (o_pin_pullup == (~dir_q & data_q & {PINS{~global_pullup_disable}}));
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up mismatch");

    property p_pullup_off_on_output;
        (i_wr && i_addr == GDIO_ADDR_DIR && i_alt_sel == '0) |=> ((o_pin_pullup & $past(wmask)) == '0);
    endproperty
    a_pullup_off_on_output: assert property (p_pullup_off_on_output) else $error("pull-up on output");

    property p_pud_all;
        $rose(global_pullup_disable) |-> (((o_pin_pullup & ~i_alt_sel) == '0) && o_global_pullup_disable);
    endproperty
    a_pud_all: assert property (p_pud_all) else $error("pull-up not disabled");

    property p_reset_tri;
        @(posedge i_core_clk) disable iff (1'b0) i_srst |-> (o_pin_oe == '0 && o_pin_pullup == '0);
    endproperty
    a_reset_tri: assert property (p_reset_tri) else $error("pins driven in reset");

    property p_reset_low;
        @(posedge i_core_clk) disable iff (1'b0) i_srst |-> (o_pin_out == '0);
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("pin level driven in reset");

    property p_pud_every_pin;
        global_pullup_disable |-> (o_pin_pullup == '0);
    endproperty
    a_pud_every_pin: assert property (p_pud_every_pin) else $error("pull-up on while disabled");

    property p_alt_other_pins;
        ((o_pin_oe ^ dir_q) & ~i_alt_sel) == '0;
    endproperty
    a_alt_other_pins: assert property (p_alt_other_pins) else $error("override leaked to plain pin");

    property p_drive;
        (i_alt_sel == '0) |-> (o_pin_out == (data_q & dir_q));
    endproperty
    a_drive: assert property (p_drive) else $error("pin level mismatch");

    property p_toggle;
        (i_wr && i_addr == GDIO_ADDR_PIN) |=> (data_q == ($past(data_q) ^ $past(wmask)));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle failed");

    property p_toggle_keeps_dir;
        (i_wr && i_addr == GDIO_ADDR_PIN) |=> $stable(dir_q);
    endproperty
    a_toggle_keeps_dir: assert property (p_toggle_keeps_dir) else $error("toggle changed direction");

    property p_write_dir;
        (i_wr && i_addr == GDIO_ADDR_DIR) |=> (dir_q == $past(wmask));
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("direction write lost");

    property p_write_data;
        (i_wr && i_addr == GDIO_ADDR_DATA) |=> (data_q == $past(wmask));
    endproperty
    a_write_data: assert property (p_write_data) else $error("data write lost");

    property p_read_data;
        (i_rd && i_addr == GDIO_ADDR_DATA) |=> (o_rdata[PINS-1:0] == $past(data_q));
    endproperty
    a_read_data: assert property (p_read_data) else $error("data readback wrong");

    property p_unmapped_read;
        (i_rd && i_addr >= GDIO_ADDR_DIR_SET) |=> (o_rdata == 8'h00);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("write-only window read nonzero");

    property p_read_dir;
        (i_rd && i_addr == GDIO_ADDR_DIR) ##1 (!$past(i_srst)) |-> (o_rdata == $past(dir_q));
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("direction readback wrong");

    property p_set_bit;
        (i_wr && i_addr == GDIO_ADDR_DIR_SET) |=> (dir_q == ($past(dir_q) | $past(wmask)) && $stable(data_q));
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("bit set disturbed port");

    property p_dir_clr;
        (i_wr && i_addr == GDIO_ADDR_DIR_CLR) |=> (dir_q == ($past(dir_q) & ~$past(wmask)) && $stable(data_q));
    endproperty
    a_dir_clr: assert property (p_dir_clr) else $error("direction clear disturbed port");

    property p_data_set;
        (i_wr && i_addr == GDIO_ADDR_DATA_SET) |=> (data_q == ($past(data_q) | $past(wmask)) && $stable(dir_q));
    endproperty
    a_data_set: assert property (p_data_set) else $error("data set disturbed port");

    property p_data_clr;
        (i_wr && i_addr == GDIO_ADDR_DATA_CLR) |=> (data_q == ($past(data_q) & ~$past(wmask)) && $stable(dir_q));
    endproperty
    a_data_clr: assert property (p_data_clr) else $error("data clear disturbed port");

    property p_ctrl_high;
        (i_rd && i_addr == GDIO_ADDR_CTRL) |=> (o_rdata[7:5] == 3'h0);
    endproperty
    a_ctrl_high: assert property (p_ctrl_high) else $error("control high bits nonzero");

    property p_ctrl_top_zero;
        ctrl_q[7:5] == 3'h0;
    endproperty
    a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("control high bits stored");

    property p_sync;
        ($stable(i_pin_in) && $past(i_pin_in, 2) == i_pin_in) |-> (pin_in_sync == $past(i_pin_in));
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser delay wrong");

    property p_read_pin;
        (i_rd && i_addr == GDIO_ADDR_PIN) |=> (o_rdata[PINS-1:0] == $past(pin_in_sync));
    endproperty
    a_read_pin: assert property (p_read_pin) else $error("pin readback wrong");

    property p_idle_rdata;
        !i_rd |=> (o_rdata == 8'h00);
    endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside its cycle");

    c_toggle: cover property (i_wr && i_addr == GDIO_ADDR_PIN && wmask != '0);
    c_pullup: cover property (o_pin_pullup != '0);
    c_drive_high: cover property ((o_pin_oe & o_pin_out) != '0);
    c_pud: cover property ($rose(global_pullup_disable));
    c_set_clear: cover property (i_wr && i_addr >= GDIO_ADDR_DIR_SET && wmask != '0);
endmodule
`default_nettype wire

// ===== verification/gdio_board_model.sv
`default_nettype none
module gdio_board_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_pin_out,
    input wire logic [7:0] i_pin_oe,
    input wire logic [7:0] i_pin_pullup,
    input wire logic [7:0] i_ext_en,
    input wire logic [7:0] i_ext_val,
    output logic [7:0] o_pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Pad resolution
    // ****************************************
    // Undriven pads wander every cycle so a stale value never reads back by luck
    logic [7:0] float_q = 8'h5A;
    always @(posedge i_core_clk) begin
        float_q <= ~float_q;
    end
    // Board only drives pads the port leaves undriven
    always_comb begin
        o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val)
            | (~i_pin_oe & ~i_ext_en & i_pin_pullup) | (~i_pin_oe & ~i_ext_en & ~i_pin_pullup & float_q);
    end
endmodule
`default_nettype wire

// ===== verification/general_digital_io_port_tb.sv
`default_nettype none
module general_digital_io_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gdio_pkg::*;
    logic i_core_clk = 1'b0;
    logic clk_run = 1'b1;
    logic i_srst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_alt_sel = 8'h00;
    logic [7:0] i_alt_oe = 8'h00;
    logic [7:0] i_alt_out = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] o_rdata, o_pin_out, o_pin_oe, o_pin_pullup, pin_level;
    logic o_global_pullup_disable;
    int num_errors = 0;
    int total_checks = 0;

    always #4 i_core_clk = clk_run ? ~i_core_clk : i_core_clk;

    gdio_port #(.PINS(8)) gdio_port_inst (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_level),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup), .i_alt_sel(i_alt_sel),
        .i_alt_oe(i_alt_oe), .i_alt_out(i_alt_out), .o_global_pullup_disable(o_global_pullup_disable));

    gdio_board_model gdio_board_model_inst (.i_core_clk(i_core_clk), .i_pin_out(o_pin_out),
        .i_pin_oe(o_pin_oe), .i_pin_pullup(o_pin_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_pin_level(pin_level));

    // ****************************************
    // Checks and bus tasks
    // ****************************************
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk8("rdata", exp, o_rdata);
    endtask

    task automatic pins(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] pu);
        #1;
        chk8("pin_oe", oe, o_pin_oe);
        chk8("pin_out", out, o_pin_out);
        chk8("pin_pullup", pu, o_pin_pullup);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        results();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_srst <= 1'b0;
        for (int a = 1; a < 8; a++) begin
            rd(a[2:0], 8'h00);
        end
        $display("test reset_values done");
        wr(GDIO_ADDR_CTRL, 8'hFF);
        rd(GDIO_ADDR_CTRL, 8'h1F);
        chk8("pud", 8'h01, {7'h00, o_global_pullup_disable});
        $display("test control done");
        for (int p = 1; p >= 0; p--) begin
            wr(GDIO_ADDR_CTRL, p ? 8'h10 : 8'h00);
            // Data before direction so no output pin passes through output low
            wr(GDIO_ADDR_DATA, 8'hA5);
            wr(GDIO_ADDR_DIR, 8'h0F);
            pins(8'h0F, 8'h05, p ? 8'h00 : 8'hA0);
        end
        $display("test pin_config done");
        ext_en <= 8'h50;
        ext_val <= 8'h40;
        repeat (3) @(posedge i_core_clk);
        rd(GDIO_ADDR_PIN, 8'hE5);
        wr(GDIO_ADDR_DATA, 8'hA7);
        @(posedge i_core_clk);
        rd(GDIO_ADDR_PIN, 8'hE7);
        $display("test pin_read done");
        wr(GDIO_ADDR_DATA_CLR, 8'h20);
        pins(8'h0F, 8'h07, 8'h80);
        wr(GDIO_ADDR_DIR_SET, 8'h80);
        pins(8'h8F, 8'h87, 8'h00);
        rd(GDIO_ADDR_DIR, 8'h8F);
        rd(GDIO_ADDR_DATA, 8'h87);
        wr(GDIO_ADDR_DIR_CLR, 8'h08);
        wr(GDIO_ADDR_PIN, 8'h91);
        rd(GDIO_ADDR_DATA, 8'h16);
        pins(8'h87, 8'h06, 8'h10);
        rd(GDIO_ADDR_DIR, 8'h87);
        $display("test set_clear_toggle done");
        i_alt_sel <= 8'h81;
        i_alt_oe <= 8'h01;
        i_alt_out <= 8'h01;
        @(posedge i_core_clk);
        pins(8'h07, 8'h07, 8'h10);
        i_alt_sel <= 8'h00;
        wr(GDIO_ADDR_DATA_SET, 8'h08);
        pins(8'h87, 8'h06, 8'h18);
        rd(GDIO_ADDR_DATA, 8'h1E);
        $display("test alternate done");
        // Clock stopped low while reset rises: pads must float at once
        @(negedge i_core_clk);
        clk_run = 1'b0;
        #2;
        i_srst = 1'b1;
        pins(8'h00, 8'h00, 8'h00);
        #19;
        pins(8'h00, 8'h00, 8'h00);
        clk_run = 1'b1;
        repeat (6) @(posedge i_core_clk);
        i_srst <= 1'b0;
        rd(GDIO_ADDR_DIR, 8'h00);
        rd(GDIO_ADDR_DATA, 8'h00);
        $display("test clockless_reset done");
        results();
    end
endmodule
`default_nettype wire
